/* File: include/xbl_regs.vh */
// Purpose: Constants for the bit-serial X.21 line interface.
// Assumes: Included by bare name from the design files.
// Notes: Field positions refer to the scanner data byte.
`ifndef XBL_REGS_VH
`define XBL_REGS_VH

// ----------------------------------------
// Write A field positions
// ----------------------------------------
`define XBL_WA_XMIT_MODE 0
`define XBL_WA_EXT_CLK 1
`define XBL_WA_DIAG_MODE 2
`define XBL_WA_TERM_RDY 3
`define XBL_WA_RATE_SEL 4
`define XBL_WA_SWITCHED 5
`define XBL_WA_OSC_LO 6
`define XBL_WA_OSC_HI 7
`define XBL_WA_RST 8'h00

// ----------------------------------------
// Write B field positions
// ----------------------------------------
`define XBL_WB_SEND_DATA 0
`define XBL_WB_RTS 1
`define XBL_WB_RST 6'h00

// ----------------------------------------
// Read B and read C field positions
// ----------------------------------------
`define XBL_RB_SVC 0
`define XBL_RB_RCV_BUF 1
`define XBL_RB_LINE_CHG 2
`define XBL_RB_CTS 3
`define XBL_RB_DSR 4
`define XBL_RB_INDICATE 5
`define XBL_RC_OVERRUN 6
`define XBL_RC_RX_LINE 7

// ----------------------------------------
// Timing counts in bit times
// ----------------------------------------
`define XBL_CTS_NS_BITS 5'd26
`define XBL_DSR_OFF_BITS 5'd17
`define XBL_CTS_SW_BITS 5'd24
`define XBL_SW_PRESCALE 5'd24

// ----------------------------------------
// Line levels and switched patterns
// ----------------------------------------
`define XBL_MARK 1'b1
`define XBL_PAT_NOT_READY 4'h5
`define XBL_PAT_READY 4'hF
`define XBL_PAT_CALL 4'h0

`endif

/* File: rtl/xbl_sync3.v */
// Purpose: Three-stage synchroniser for pins entering the clk domain.
// Assumes: Inputs are asynchronous levels.
// Notes: Output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module xbl_sync3 #(
    parameter WIDTH = 1
) (
    // Clocking
    input wire clk,
    input wire rst,
    input wire ce,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;

    always @(posedge clk) begin
        if (rst) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // xbl_sync3
`default_nettype wire

/* File: rtl/xbl_fifo.v */
// Purpose: Send-data FIFO between scanner writes and the transmit buffer.
// Assumes: One clock; push and pop are valid/ready handshakes.
// Notes: Read data comes from an output register; total hold is DEPTH plus one.
`timescale 1ns/1ps
`default_nettype none
module xbl_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clocking
    input wire clk,
    input wire rst,
    input wire ce,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire load;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    // Refill the output register when the memory holds data and the register is free or being taken
    assign load = (count_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    always @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (load) begin
                out_data <= mem[rd_ptr_q];
                out_valid <= 1'b1;
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !load) begin
                count_q <= count_q + 1'b1;
            end else if (!push && load) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // xbl_fifo
`default_nettype wire

/* File: rtl/xbl_line_if.v */
// Purpose: Bit-serial X.21 line interface between scanner and DCE.
// Assumes: Scanner strobes are one-cycle pulses on clk; DCE pins are asynchronous.
// Notes: One bit time is one falling edge of the selected strobe.
`timescale 1ns/1ps
`default_nettype none
`include "xbl_regs.vh"
module xbl_line_if #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // Clocking
    input wire clk,
    input wire rst,
    input wire ce,
    // Scanner control cycles
    input wire scan_write_a,
    input wire scan_write_b,
    input wire scan_read_a,
    input wire scan_read_b,
    input wire scan_read_c,
    input wire [7:0] scan_data_in,
    output wire scan_write_b_ready,
    output reg [7:0] scan_data_out,
    output reg scan_data_valid,
    // Service handshake
    output reg service_request,
    input wire service_ack,
    output reg overrun,
    input wire overrun_reset,
    // Strobe sources
    input wire bit_clock_control_strobe,
    input wire [3:0] osc_clk,
    // DCE pins
    input wire dce_clock,
    input wire dce_receive,
    input wire dce_indicate,
    output reg dce_transmit,
    output reg dce_control,
    // Status toward the adapter
    output reg line_change,
    output reg clear_to_send,
    output reg data_set_ready
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire [6:0] pins_s;
    wire dce_clock_s;
    wire rx_s;
    wire indicate_s;
    wire [3:0] osc_s;

    xbl_sync3 #(
        .WIDTH(7)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .async_in({osc_clk, dce_indicate, dce_receive, dce_clock}),
        .sync_out(pins_s)
    );

    assign dce_clock_s = pins_s[0];
    assign rx_s = pins_s[1];
    assign indicate_s = pins_s[2];
    assign osc_s = pins_s[6:3];

    // ----------------------------------------
    // Scanner latches
    // ----------------------------------------
    reg [7:0] wa_q;
    reg [5:0] wb_q;
    wire xmit_mode;
    wire ext_clk;
    wire diag_mode;
    wire term_rdy;
    wire rate_sel;
    wire switched;
    wire [1:0] osc_sel;
    wire rts;

    assign xmit_mode = wa_q[`XBL_WA_XMIT_MODE];
    assign ext_clk = wa_q[`XBL_WA_EXT_CLK];
    assign diag_mode = wa_q[`XBL_WA_DIAG_MODE];
    assign term_rdy = wa_q[`XBL_WA_TERM_RDY];
    assign rate_sel = wa_q[`XBL_WA_RATE_SEL];
    assign switched = wa_q[`XBL_WA_SWITCHED];
    assign osc_sel = wa_q[`XBL_WA_OSC_HI:`XBL_WA_OSC_LO];
    assign rts = wb_q[`XBL_WB_RTS];

    always @(posedge clk) begin
        if (rst) begin
            wa_q <= `XBL_WA_RST;
            wb_q <= `XBL_WB_RST;
        end else if (ce) begin
            if (scan_write_a) begin
                wa_q <= scan_data_in;
            end
            if (scan_write_b && scan_write_b_ready) begin
                wb_q <= scan_data_in[5:0];
            end
        end
    end

    // ----------------------------------------
    // Send-data FIFO
    // ----------------------------------------
    wire fifo_valid;
    wire fifo_data;
    wire strobe_fall;

    xbl_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(scan_write_b),
        .in_ready(scan_write_b_ready),
        .in_data(scan_data_in[`XBL_WB_SEND_DATA]),
        .out_valid(fifo_valid),
        .out_ready(strobe_fall),
        .out_data(fifo_data)
    );

    // ----------------------------------------
    // Strobe selection and edge detection
    // ----------------------------------------
    reg clk_shift_q;
    reg strobe_prev_q;
    reg strobe_sel;

    always @* begin
        if (ext_clk) begin
            strobe_sel = clk_shift_q;
        end else if (xmit_mode) begin
            strobe_sel = osc_s[osc_sel];
        end else begin
            strobe_sel = bit_clock_control_strobe;
        end
    end

    assign strobe_fall = strobe_prev_q && !strobe_sel;

    always @(posedge clk) begin
        if (rst) begin
            clk_shift_q <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else if (ce) begin
            clk_shift_q <= dce_clock_s;
            strobe_prev_q <= strobe_sel;
        end
    end

    // ----------------------------------------
    // Service request and overrun
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            service_request <= 1'b0;
            overrun <= 1'b0;
        end else if (ce) begin
            if (strobe_fall) begin
                service_request <= 1'b1;
            end else if (service_ack) begin
                service_request <= 1'b0;
            end
            if (strobe_fall && service_request) begin
                overrun <= 1'b1;
            end else if (overrun_reset) begin
                overrun <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmit and receive buffers
    // ----------------------------------------
    reg xmit_buf_q;
    reg rcv_buf_q;
    reg [1:0] pat_phase_q;
    wire incoming;

    assign incoming = diag_mode ? xmit_buf_q : rx_s;

    always @(posedge clk) begin
        if (rst) begin
            xmit_buf_q <= `XBL_MARK;
            rcv_buf_q <= `XBL_MARK;
            pat_phase_q <= 2'd0;
            line_change <= 1'b0;
        end else if (ce) begin
            line_change <= (incoming != rcv_buf_q);
            if (strobe_fall) begin
                if (fifo_valid) begin
                    xmit_buf_q <= fifo_data;
                end
                rcv_buf_q <= incoming;
                pat_phase_q <= pat_phase_q + 2'd1;
            end
        end
    end

    // ----------------------------------------
    // Line drive, nonswitched and switched
    // ----------------------------------------
    reg [3:0] pat;
    reg use_pat;
    reg ctl_d;

    always @* begin
        pat = `XBL_PAT_NOT_READY;
        use_pat = 1'b0;
        ctl_d = rts;
        if (switched) begin
            use_pat = 1'b1;
            ctl_d = 1'b0;
            if (diag_mode) begin
                pat = `XBL_PAT_CALL;
            end else if (term_rdy && !rts) begin
                pat = `XBL_PAT_READY;
            end else if (term_rdy && rts && rate_sel) begin
                pat = `XBL_PAT_CALL;
                ctl_d = 1'b1;
            end else if (term_rdy && rts) begin
                use_pat = 1'b0;
                ctl_d = 1'b1;
            end else begin
                pat = `XBL_PAT_NOT_READY;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            dce_transmit <= `XBL_MARK;
            dce_control <= 1'b0;
        end else if (ce) begin
            dce_transmit <= use_pat ? pat[3 - pat_phase_q] : xmit_buf_q;
            dce_control <= ctl_d;
        end
    end

    // ----------------------------------------
    // Clear to send delay
    // ----------------------------------------
    reg [4:0] cts_cnt_q;
    reg [4:0] pre_cnt_q;
    wire sw_tick;

    // Switched timer ticks once per 24 bit times
    assign sw_tick = strobe_fall && (pre_cnt_q == `XBL_SW_PRESCALE - 5'd1);

    always @(posedge clk) begin
        if (rst) begin
            cts_cnt_q <= 5'd0;
            pre_cnt_q <= 5'd0;
            clear_to_send <= 1'b0;
        end else if (ce) begin
            if (switched) begin
                cts_cnt_q <= 5'd0;
                if (rts == clear_to_send) begin
                    pre_cnt_q <= 5'd0;
                end else if (sw_tick) begin
                    pre_cnt_q <= 5'd0;
                    clear_to_send <= rts;
                end else if (strobe_fall) begin
                    pre_cnt_q <= pre_cnt_q + 5'd1;
                end
            end else begin
                pre_cnt_q <= 5'd0;
                if (!rts) begin
                    cts_cnt_q <= 5'd0;
                    clear_to_send <= 1'b0;
                end else if (cts_cnt_q == `XBL_CTS_NS_BITS) begin
                    clear_to_send <= 1'b1;
                end else if (strobe_fall) begin
                    cts_cnt_q <= cts_cnt_q + 5'd1;
                end
            end
        end
    end

    // ----------------------------------------
    // Data set ready drop delay
    // ----------------------------------------
    reg [4:0] dsr_cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            dsr_cnt_q <= 5'd0;
            data_set_ready <= 1'b0;
        end else if (ce) begin
            if (rx_s || indicate_s) begin
                dsr_cnt_q <= 5'd0;
                if (indicate_s) begin
                    data_set_ready <= 1'b1;
                end
            end else if (dsr_cnt_q == `XBL_DSR_OFF_BITS) begin
                data_set_ready <= 1'b0;
            end else if (strobe_fall) begin
                dsr_cnt_q <= dsr_cnt_q + 5'd1;
            end
        end
    end

    // ----------------------------------------
    // Scanner read answers
    // ----------------------------------------
    reg [7:0] rb;

    always @* begin
        rb = 8'h00;
        rb[`XBL_RB_SVC] = service_request;
        rb[`XBL_RB_RCV_BUF] = rcv_buf_q;
        rb[`XBL_RB_LINE_CHG] = line_change;
        rb[`XBL_RB_CTS] = clear_to_send;
        rb[`XBL_RB_DSR] = data_set_ready;
        rb[`XBL_RB_INDICATE] = indicate_s;
    end

    always @(posedge clk) begin
        if (rst) begin
            scan_data_out <= 8'h00;
            scan_data_valid <= 1'b0;
        end else if (ce) begin
            scan_data_valid <= scan_read_a || scan_read_b || scan_read_c;
            if (scan_read_a) begin
                scan_data_out <= wa_q;
            end else if (scan_read_b) begin
                scan_data_out <= rb;
            end else if (scan_read_c) begin
                scan_data_out <= {rx_s, overrun, wb_q};
            end
        end
    end
endmodule // xbl_line_if
`default_nettype wire

/* File: tb/xbl_line_if_monitor.sv */
// Purpose: Concurrent checks on the line interface ports.
// Assumes: Scanner pulses and strobe are sampled on rising clk.
// Notes: Strobe checks apply in bit clock control mode only.
`timescale 1ns/1ps
`default_nettype none
module xbl_line_if_monitor (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Scanner side
    input wire logic scan_write_a,
    input wire logic scan_write_b,
    input wire logic scan_read_a,
    input wire logic scan_read_b,
    input wire logic scan_read_c,
    input wire logic [7:0] scan_data_in,
    input wire logic scan_write_b_ready,
    input wire logic [7:0] scan_data_out,
    input wire logic scan_data_valid,
    // Service handshake
    input wire logic service_request,
    input wire logic service_ack,
    input wire logic overrun,
    input wire logic overrun_reset,
    input wire logic bit_clock_control_strobe,
    // Status
    input wire logic line_change,
    input wire logic clear_to_send,
    input wire logic data_set_ready
);
    logic [7:0] wa_q;
    logic [5:0] wb_q;
    logic bcc_q;
    wire bcc_mode = !wa_q[0] && !wa_q[1];
    wire fall_w = ce && bcc_mode && bcc_q && !bit_clock_control_strobe;
    wire rd_c_w = ce && scan_read_c && !scan_read_a && !scan_read_b;
    wire rd_b_w = ce && scan_read_b && !scan_read_a;
    // ----------------------------------------
    // Shadow of scanner writes
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            wa_q <= 8'h00;
            wb_q <= 6'h00;
            bcc_q <= 1'b0;
        end else if (ce) begin
            bcc_q <= bit_clock_control_strobe;
            if (scan_write_a) wa_q <= scan_data_in;
            if (scan_write_b && scan_write_b_ready) wb_q <= scan_data_in[5:0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_fall;
        fall_w;
    endsequence
    sequence s_pending;
        fall_w && service_request;
    endsequence
    sequence s_any_read;
        ce && (scan_read_a || scan_read_b || scan_read_c);
    endsequence
    chk_read_valid: assert property (s_any_read |=> scan_data_valid)
        else $error("read not answered");
    chk_valid_cause: assert property (scan_data_valid |-> $past(ce && (scan_read_a
        || scan_read_b || scan_read_c))) else $error("valid without read");
    chk_req_set: assert property (s_fall |=> service_request)
        else $error("strobe fall did not set request");
    chk_ack_clears: assert property (ce && bcc_mode && service_ack && !fall_w
        |=> !service_request) else $error("ack did not clear request");
    chk_overrun_set: assert property (s_pending |=> overrun)
        else $error("overrun not set");
    chk_overrun_hold: assert property (ce && overrun && !overrun_reset |=> overrun)
        else $error("overrun lost");
    chk_overrun_cause: assert property ($rose(overrun) |-> $past(service_request))
        else $error("overrun without pending request");
    chk_read_a_echo: assert property (ce && scan_read_a |=> scan_data_out == $past(wa_q))
        else $error("read a mismatch");
    chk_read_c_echo: assert property (rd_c_w |=> scan_data_out[6:0] == $past({overrun,
        wb_q})) else $error("read c mismatch");
    chk_read_b_stat: assert property (rd_b_w |=> {scan_data_out[4:2], scan_data_out[0]}
        == $past({data_set_ready, clear_to_send, line_change, service_request}))
        else $error("read b mismatch");
    chk_cts_drop: assert property (!wa_q[5] && !wb_q[1] && $past(!wb_q[1] && !wa_q[5])
        |-> !clear_to_send) else $error("clear to send without request");
endmodule // xbl_line_if_monitor
bind xbl_line_if xbl_line_if_monitor u_mon (.*);
`default_nettype wire

/* File: tb/xbl_dce_model.sv */
// Purpose: Line side terminal equipment for the bench.
// Assumes: Clock period 160 ns, runs only within frames.
// Notes: Receive and indicate levels are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module xbl_dce_model (
    // Control from bench
    input wire logic frame_on,
    input wire logic rx_level,
    input wire logic ind_level,
    // Pins
    output logic dce_clock,
    output logic dce_receive,
    output logic dce_indicate
);
    assign dce_receive = rx_level;
    assign dce_indicate = ind_level;
    // Clock stands low outside frames; phase offset from clk
    initial begin
        dce_clock = 1'b0;
        #3.7;
        forever begin
            #80;
            dce_clock = frame_on ? ~dce_clock : 1'b0;
        end
    end
endmodule // xbl_dce_model
`default_nettype wire

/* File: tb/xbl_line_if_tb_top.sv */
// Purpose: Directed tests of the line interface.
// Assumes: Inputs change on falling clk.
// Notes: Scanner role is played by the tasks below.
`timescale 1ns/1ps
`default_nettype none
module xbl_line_if_tb_top;
    localparam int DEPTH = 16;
    localparam logic [7:0] WAV [0:3] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
    localparam logic [7:0] SWV [0:2] = '{8'h20, 8'h28, 8'h38};
    logic clk, rst, ce, scan_write_a, scan_write_b, scan_read_a, scan_read_b, scan_read_c;
    logic [7:0] scan_data_in, scan_data_out;
    logic scan_write_b_ready, scan_data_valid, service_request, service_ack, overrun;
    logic overrun_reset, bit_clock_control_strobe, dce_clock, dce_receive, dce_indicate;
    logic [3:0] osc_clk;
    logic dce_transmit, dce_control, line_change, clear_to_send, data_set_ready;
    logic frame_on, rx_level, ind_level;
    int n_errors = 0;
    int cmp_count = 0;
    xbl_line_if #(.FIFO_DEPTH(DEPTH), .FIFO_AW(4)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .scan_write_a(scan_write_a), .scan_write_b(scan_write_b), .scan_read_a(scan_read_a),
        .scan_read_b(scan_read_b), .scan_read_c(scan_read_c), .scan_data_in(scan_data_in),
        .scan_write_b_ready(scan_write_b_ready), .scan_data_out(scan_data_out),
        .scan_data_valid(scan_data_valid), .service_request(service_request),
        .service_ack(service_ack), .overrun(overrun), .overrun_reset(overrun_reset),
        .bit_clock_control_strobe(bit_clock_control_strobe), .osc_clk(osc_clk),
        .dce_clock(dce_clock), .dce_receive(dce_receive), .dce_indicate(dce_indicate),
        .dce_transmit(dce_transmit), .dce_control(dce_control), .line_change(line_change),
        .clear_to_send(clear_to_send), .data_set_ready(data_set_ready));
    xbl_dce_model u_dce (.frame_on(frame_on), .rx_level(rx_level), .ind_level(ind_level),
        .dce_clock(dce_clock), .dce_receive(dce_receive), .dce_indicate(dce_indicate));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Free-running internal oscillators
    always begin
        repeat (4) @(negedge clk);
        osc_clk = osc_clk + 4'h1;
    end
    // ----------------------------------------
    // Scanner tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic b, input logic [7:0] v);
        scan_data_in = v;
        scan_write_a = !b;
        scan_write_b = b;
        tick(1);
        {scan_write_a, scan_write_b} = 2'b00;
        tick(1);
    endtask
    task automatic rd(input int k, output logic [7:0] d);
        scan_read_a = (k == 0);
        scan_read_b = (k == 1);
        scan_read_c = (k == 2);
        tick(1);
        {scan_read_a, scan_read_b, scan_read_c} = 3'b000;
        d = scan_data_out;
        chk("scan_data_valid", 8'h01, scan_data_valid);
    endtask
    task automatic ack();
        service_ack = 1'b1;
        tick(1);
        service_ack = 1'b0;
        tick(1);
    endtask
    task automatic strobe(input logic a);
        bit_clock_control_strobe = 1'b1;
        tick(1);
        bit_clock_control_strobe = 1'b0;
        tick(2);
        if (a) ack();
    endtask
    task automatic wait_req(input int n);
        for (int i = 0; i < n && service_request !== 1'b1; i++) tick(1);
        chk("service_request", 8'h01, service_request);
        ack();
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic [3:0] p;
        int n;
        {rst, ce, scan_write_a, scan_write_b, scan_read_a, scan_read_b, scan_read_c} = 7'h60;
        {service_ack, overrun_reset, bit_clock_control_strobe} = 3'b000;
        {frame_on, rx_level, ind_level} = 3'b000;
        scan_data_in = 8'h00;
        osc_clk = 4'h0;
        tick(20);
        rst = 1'b0;
        tick(5);
        chk("service_request", 8'h00, service_request);
        chk("overrun", 8'h00, overrun);
        chk("dce_transmit", 8'h01, dce_transmit);
        chk("scan_write_b_ready", 8'h01, scan_write_b_ready);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(0, WAV[i]);
            rd(0, d);
            chk("read_a", WAV[i], d);
        end
        wr(0, 8'h00);
        wr(1, 8'h2A);
        rd(2, d);
        chk("read_c", 8'h2A, d);
        wr(1, 8'h15);
        $display("test scanner cycles done");
        strobe(0);
        rd(1, d);
        chk("read_b_request", 8'h01, d[0]);
        chk("dce_transmit", 8'h00, dce_transmit);
        ack();
        rd(1, d);
        chk("read_b_request", 8'h00, d[0]);
        strobe(0);
        chk("dce_transmit", 8'h01, dce_transmit);
        strobe(0);
        rd(2, d);
        chk("read_c_overrun", 8'h01, d[6]);
        overrun_reset = 1'b1;
        tick(1);
        overrun_reset = 1'b0;
        chk("overrun", 8'h00, overrun);
        ack();
        $display("test service done");
        rx_level = 1'b1;
        tick(6);
        chk("line_change", 8'h01, line_change);
        strobe(1);
        rd(1, d);
        chk("read_b_rcv", 8'h01, d[1]);
        chk("line_change", 8'h00, line_change);
        rx_level = 1'b0;
        tick(6);
        strobe(1);
        rd(2, d);
        chk("read_c_rx", 8'h00, d[7]);
        wr(0, 8'h04);
        tick(2);
        chk("line_change", 8'h01, line_change);
        strobe(1);
        rd(1, d);
        chk("read_b_rcv", 8'h01, d[1]);
        wr(0, 8'h00);
        $display("test receive done");
        wr(1, 8'h02);
        tick(2);
        chk("dce_control", 8'h01, dce_control);
        for (int i = 1; i <= 26; i++) begin
            strobe(1);
            if (i >= 25) chk("clear_to_send", i == 26, clear_to_send);
        end
        wr(1, 8'h00);
        tick(2);
        chk("clear_to_send", 8'h00, clear_to_send);
        ind_level = 1'b1;
        tick(6);
        chk("data_set_ready", 8'h01, data_set_ready);
        ind_level = 1'b0;
        tick(6);
        for (int i = 1; i <= 17; i++) begin
            strobe(1);
            if (i >= 16) chk("data_set_ready", i < 17, data_set_ready);
        end
        $display("test modem delays done");
        n = 0;
        while (scan_write_b_ready === 1'b1 && n < 20) begin
            wr(1, {7'h00, n[0]});
            n++;
        end
        chk("fifo_fill", DEPTH + 1, n);
        wr(1, 8'h01);
        rd(2, d);
        chk("read_c_refused", 8'h00, d[5:0]);
        for (int i = 0; i < n; i++) begin
            strobe(1);
            chk("dce_transmit", i % 2, dce_transmit);
        end
        chk("scan_write_b_ready", 8'h01, scan_write_b_ready);
        $display("test buffer done");
        wr(0, 8'h02);
        frame_on = 1'b1;
        wait_req(200);
        wait_req(200);
        frame_on = 1'b0;
        tick(30);
        ack();
        tick(60);
        chk("service_request", 8'h00, service_request);
        for (int k = 0; k < 4; k++) begin
            wr(0, {k[1:0], 6'h01});
            tick(6);
            ack();
            wait_req(300);
        end
        wr(0, 8'h03);
        frame_on = 1'b1;
        wait_req(200);
        frame_on = 1'b0;
        tick(30);
        ack();
        wr(0, 8'h00);
        overrun_reset = 1'b1;
        tick(1);
        overrun_reset = 1'b0;
        $display("test strobe sources done");
        for (int k = 0; k < 3; k++) begin
            wr(1, (k == 2) ? 8'h02 : 8'h00);
            wr(0, SWV[k]);
            strobe(1);
            strobe(1);
            for (int i = 0; i < 4; i++) begin
                strobe(1);
                p = {p[2:0], dce_transmit};
            end
            d = (k == 0) ? (p[0] ? 8'h05 : 8'h0A) : ((k == 1) ? 8'h0F : 8'h00);
            chk("switched_pattern", d, p);
            chk("dce_control", k == 2, dce_control);
        end
        for (int i = 7; i <= 24; i++) begin
            strobe(1);
            if (i >= 23) chk("clear_to_send", i == 24, clear_to_send);
        end
        wr(0, 8'h00);
        wr(1, 8'h00);
        $display("test switched done");
        end_of_test();
    end
endmodule // xbl_line_if_tb_top
`default_nettype wire
